//--- rtl/pmc_power_ctrl.v
// power mode controller: idle, power-down and standby clock gating
`timescale 1ns/100ps
`include "pmc_regs.vh"
module pmc_power_ctrl #(
    parameter N_IRQ       = 8,
    parameter SINGLE_PAGE = 1
) (
    input  wire                   clk_in,
    input  wire                   nrst_in,
    input  wire [`PMC_ADDR_W-1:0] addr_in,
    input  wire [7:0]             wdata_in,
    input  wire                   wr_in,
    input  wire                   rd_in,
    output reg  [7:0]             rdata_out,
    input  wire [N_IRQ-1:0]       irq_in,
    input  wire                   ext_irq_level_n_in,
    input  wire                   cmp_irq_in,
    input  wire                   hw_reset_in,
    output reg                    cpu_clk_en_out,
    output reg                    acq_clk_en_out,
    output reg                    disp_clk_en_out,
    output reg                    periph_clk_en_out,
    output reg                    sadc_clk_en_out,
    output reg                    osc_en_out,
    output reg                    hold_state_out,
    output reg                    aux_mem_lost_out,
    output reg                    soft_reset_out,
    output reg                    resume_out
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg  [7:0] power_control_reg_q;
    reg  [7:0] power_control_reg_d;
    reg  [7:0] bank_q;
    reg  [7:0] bank_d;
    reg  [7:0] wake_en_q;
    reg  [7:0] wake_en_d;
    reg        aux_lost_q;
    reg        aux_lost_d;
    reg        cpu_clk_en_d;
    reg        acq_clk_en_d;
    reg        disp_clk_en_d;
    reg        periph_clk_en_d;
    reg        sadc_clk_en_d;
    reg        osc_en_d;
    reg        hold_state_d;
    reg        aux_mem_lost_d;
    reg        soft_reset_d;
    reg        resume_d;
    reg  [7:0] rdata_d;
    reg  [7:0] status_word;

    // ------------------------------------------------------------------
    // decodes and mode terms
    // ------------------------------------------------------------------
    wire       wake_idle;
    wire       wake_pdown;
    wire       reset_done;
    wire       wr_power_control_reg;
    wire       wr_bank;
    wire       wr_wake_en;
    wire       rd_status;
    wire       idle_req;
    wire       pdown_req;
    wire       pdown_mode;
    wire       idle_mode;
    wire       standby;
    wire       low_power;
    wire       idle_exit;
    wire       pdown_exit;
    wire       single_page;

    assign wr_power_control_reg     = wr_in & (addr_in == `PMC_ADDR_POWER_CONTROL_REG);
    assign wr_bank     = wr_in & (addr_in == `PMC_ADDR_BANK);
    assign wr_wake_en  = wr_in & (addr_in == `PMC_ADDR_WAKE_EN);
    assign rd_status   = rd_in & (addr_in == `PMC_ADDR_STATUS);
    assign idle_req    = power_control_reg_q[`PMC_POWER_CONTROL_REG_IDLE];
    assign pdown_req   = power_control_reg_q[`PMC_POWER_CONTROL_REG_PDOWN];
    // power-down wins when both request bits are set
    assign pdown_mode  = pdown_req;
    assign idle_mode   = idle_req & ~pdown_req;
    assign low_power   = idle_mode | pdown_mode;
    // multi-page builds tie standby off; the bit still reads back
    assign single_page = (SINGLE_PAGE != 0);
    assign standby     = bank_q[`PMC_BANK_STANDBY] & single_page;
    assign idle_exit   = idle_mode & wake_idle;
    assign pdown_exit  = pdown_mode & wake_pdown;

    // ------------------------------------------------------------------
    // sub blocks
    // ------------------------------------------------------------------
    pmc_wake_detect #(
        .N_IRQ (N_IRQ)
    ) u_wake (
        .clk_in             (clk_in),
        .nrst_in            (nrst_in),
        .irq_in             (irq_in),
        .irq_en_in          (wake_en_q[N_IRQ-1:0]),
        .ext_irq_level_n_in (ext_irq_level_n_in),
        .cmp_irq_in         (cmp_irq_in),
        .wake_idle_out      (wake_idle),
        .wake_pdown_out     (wake_pdown)
    );

    pmc_reset_filter #(
        .CNT_W (5),
        .CLKS  (`PMC_RST_CLKS)
    ) u_rst (
        .clk_in         (clk_in),
        .nrst_in        (nrst_in),
        .hw_reset_in    (hw_reset_in),
        .reset_done_out (reset_done)
    );

    // ------------------------------------------------------------------
    // status word and read data
    // ------------------------------------------------------------------
    always @* begin
        status_word                   = 8'h00;
        status_word[`PMC_ST_IDLE]     = idle_mode;
        status_word[`PMC_ST_PDOWN]    = pdown_mode;
        status_word[`PMC_ST_STANDBY]  = standby;
        status_word[`PMC_ST_OSC_ON]   = ~pdown_mode;
        status_word[`PMC_ST_AUX_LOST] = aux_lost_q;
    end

    // unmapped addresses and idle cycles read as zero
    always @* begin
        rdata_d = 8'h00;
        if (rd_in) begin
            case (addr_in)
                `PMC_ADDR_POWER_CONTROL_REG: begin
                    rdata_d = power_control_reg_q;
                end
                `PMC_ADDR_BANK: begin
                    rdata_d = bank_q;
                end
                `PMC_ADDR_WAKE_EN: begin
                    rdata_d = wake_en_q;
                end
                `PMC_ADDR_STATUS: begin
                    rdata_d = status_word;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // next register values
    // ------------------------------------------------------------------
    always @* begin
        power_control_reg_d    = power_control_reg_q;
        bank_d    = bank_q;
        wake_en_d = wake_en_q;
        if (reset_done) begin
            // registers to defined values, other ram untouched
            power_control_reg_d    = `PMC_POWER_CONTROL_REG_RST;
            bank_d    = `PMC_BANK_RST;
            wake_en_d = `PMC_WAKE_EN_RST;
        end else begin
            if (wr_power_control_reg) begin
                power_control_reg_d = wdata_in;
            end
            if (wr_bank) begin
                bank_d = wdata_in;
            end
            if (wr_wake_en) begin
                wake_en_d = wdata_in;
            end
            // hardware clear wins over a same-cycle software write
            if (idle_exit) begin
                power_control_reg_d[`PMC_POWER_CONTROL_REG_IDLE] = 1'b0;
            end
            if (pdown_exit) begin
                power_control_reg_d[`PMC_POWER_CONTROL_REG_PDOWN] = 1'b0;
                power_control_reg_d[`PMC_POWER_CONTROL_REG_IDLE]  = 1'b0;
            end
            // standby bit is untouched by wake-up, so it persists
        end
    end

    // set side wins when a status read meets power-down
    always @* begin
        aux_lost_d = aux_lost_q;
        if (pdown_mode) begin
            aux_lost_d = 1'b1;
        end else if (rd_status) begin
            aux_lost_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // next output values
    // ------------------------------------------------------------------
    always @* begin
        cpu_clk_en_d    = ~low_power;
        acq_clk_en_d    = ~(low_power | standby);
        disp_clk_en_d   = ~(low_power | standby);
        periph_clk_en_d = ~pdown_mode;
        sadc_clk_en_d   = ~low_power;
        osc_en_d        = ~pdown_mode;
        hold_state_d    = low_power;
        aux_mem_lost_d  = aux_lost_q;
        soft_reset_d    = reset_done;
        // a reset in the wake-up cycle takes precedence over resuming
        resume_d        = (idle_exit | pdown_exit) & ~reset_done;
    end

    // ------------------------------------------------------------------
    // control register flops
    // ------------------------------------------------------------------
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            power_control_reg_q <= `PMC_POWER_CONTROL_REG_RST;
        end else begin
            power_control_reg_q <= power_control_reg_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bank_q <= `PMC_BANK_RST;
        end else begin
            bank_q <= bank_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wake_en_q <= `PMC_WAKE_EN_RST;
        end else begin
            wake_en_q <= wake_en_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aux_lost_q <= 1'b0;
        end else begin
            aux_lost_q <= aux_lost_d;
        end
    end

    // ------------------------------------------------------------------
    // output flops
    // ------------------------------------------------------------------
    // one flop per pin, so no decode glitch ever reaches a clock gate
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cpu_clk_en_out <= 1'b1;
        end else begin
            cpu_clk_en_out <= cpu_clk_en_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acq_clk_en_out <= 1'b1;
        end else begin
            acq_clk_en_out <= acq_clk_en_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            disp_clk_en_out <= 1'b1;
        end else begin
            disp_clk_en_out <= disp_clk_en_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            periph_clk_en_out <= 1'b1;
        end else begin
            periph_clk_en_out <= periph_clk_en_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sadc_clk_en_out <= 1'b1;
        end else begin
            sadc_clk_en_out <= sadc_clk_en_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            osc_en_out <= 1'b1;
        end else begin
            osc_en_out <= osc_en_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_state_out <= 1'b0;
        end else begin
            hold_state_out <= hold_state_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aux_mem_lost_out <= 1'b0;
        end else begin
            aux_mem_lost_out <= aux_mem_lost_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            soft_reset_out <= 1'b0;
        end else begin
            soft_reset_out <= soft_reset_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            resume_out <= 1'b0;
        end else begin
            resume_out <= resume_d;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rdata_d;
        end
    end
endmodule // pmc_power_ctrl

//--- rtl/pmc_regs.vh
// constants for the power mode controller registers and timing
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ----------------------------------------------------------------------
// register addresses (own map)
// ----------------------------------------------------------------------
`define PMC_ADDR_W          4
`define PMC_ADDR_POWER_CONTROL_REG       4'h0
`define PMC_ADDR_BANK       4'h1
`define PMC_ADDR_STATUS     4'h2
`define PMC_ADDR_WAKE_EN    4'h3

// ----------------------------------------------------------------------
// power control register fields
// ----------------------------------------------------------------------
`define PMC_POWER_CONTROL_REG_IDLE       0
`define PMC_POWER_CONTROL_REG_PDOWN      1
`define PMC_POWER_CONTROL_REG_RST        8'h00

// ----------------------------------------------------------------------
// bank select register fields
// ----------------------------------------------------------------------
`define PMC_BANK_STANDBY    7
`define PMC_BANK_RST        8'h00

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define PMC_ST_IDLE         0
`define PMC_ST_PDOWN        1
`define PMC_ST_STANDBY      2
`define PMC_ST_OSC_ON       3
`define PMC_ST_AUX_LOST     4

`define PMC_WAKE_EN_RST     8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PMC_CLK_MHZ         200
`define PMC_MCYC_CLKS       12
`define PMC_RST_MCYC        2
`define PMC_RST_CLKS        (`PMC_MCYC_CLKS * `PMC_RST_MCYC)

`endif

//--- rtl/pmc_reset_filter.v
// qualifies the external hardware reset: must stand for two machine cycles
`timescale 1ns/100ps
module pmc_reset_filter #(
    parameter CNT_W  = 5,
    parameter CLKS   = 24
) (
    input  wire clk_in,
    input  wire nrst_in,
    input  wire hw_reset_in,
    output reg  reset_done_out
);
    reg [CNT_W-1:0] cnt_q;

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q          <= {CNT_W{1'b0}};
            reset_done_out <= 1'b0;
        end else if (!hw_reset_in) begin
            cnt_q          <= {CNT_W{1'b0}};
            reset_done_out <= 1'b0;
        end else if (cnt_q != CLKS[CNT_W-1:0] - 1'b1) begin
            cnt_q          <= cnt_q + 1'b1;
            reset_done_out <= 1'b0;
        end else begin
            // pulses once the reset has been held long enough
            reset_done_out <= ~reset_done_out & (cnt_q == CLKS[CNT_W-1:0] - 1'b1);
            cnt_q          <= cnt_q + 1'b1;
        end
    end
endmodule // pmc_reset_filter

//--- rtl/pmc_wake_detect.v
// wake source detection: enabled interrupts, compare interrupt, external level
`timescale 1ns/100ps
module pmc_wake_detect #(
    parameter N_IRQ = 8
) (
    input  wire             clk_in,
    input  wire             nrst_in,
    input  wire [N_IRQ-1:0] irq_in,
    input  wire [N_IRQ-1:0] irq_en_in,
    input  wire             ext_irq_level_n_in,
    input  wire             cmp_irq_in,
    output reg              wake_idle_out,
    output reg              wake_pdown_out
);
    wire any_irq = |(irq_in & irq_en_in);

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wake_idle_out  <= 1'b0;
            wake_pdown_out <= 1'b0;
        end else begin
            wake_idle_out  <= any_irq | cmp_irq_in;
            // no clock in power-down, so only a level can be seen
            wake_pdown_out <= ~ext_irq_level_n_in | cmp_irq_in;
        end
    end
endmodule // pmc_wake_detect

//--- tb/pmc_power_sva.sv
// port assertions for the power mode controller
`timescale 1ns/100ps
`include "pmc_regs.vh"
module pmc_power_sva #(
    parameter N_IRQ = 8
) (
    input wire             clk_in,
    input wire             nrst_in,
    input wire [3:0]       addr_in,
    input wire [7:0]       wdata_in,
    input wire             wr_in,
    input wire             rd_in,
    input wire [7:0]       rdata_out,
    input wire [N_IRQ-1:0] irq_in,
    input wire             ext_irq_level_n_in,
    input wire             cmp_irq_in,
    input wire             hw_reset_in,
    input wire             cpu_clk_en_out,
    input wire             acq_clk_en_out,
    input wire             disp_clk_en_out,
    input wire             periph_clk_en_out,
    input wire             osc_en_out,
    input wire             hold_state_out,
    input wire             aux_mem_lost_out,
    input wire             soft_reset_out,
    input wire             resume_out
);
    // ------
    // helpers
    // ------
    reg  [7:0] run_q;
    // a write is only judged when no wake or reset can overtake it
    wire       quiet = run_q == 8'h00 && !hw_reset_in && irq_in == '0
                       && ext_irq_level_n_in && !cmp_irq_in;
    // saturates so a long reset hold never wraps back through the threshold
    always @(posedge clk_in or negedge nrst_in)
        if (!nrst_in) run_q <= 8'h00;
        else if (!hw_reset_in) run_q <= 8'h00;
        else if (run_q != 8'hff) run_q <= run_q + 8'h01;
    // ------
    // properties
    // ------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_idle_wr;
        wr_in && addr_in == `PMC_ADDR_POWER_CONTROL_REG && wdata_in[1:0] == 2'h1 && quiet;
    endsequence
    sequence s_pd_wr;
        wr_in && addr_in == `PMC_ADDR_POWER_CONTROL_REG && wdata_in[`PMC_POWER_CONTROL_REG_PDOWN] && quiet;
    endsequence
    sequence s_sb_wr;
        wr_in && addr_in == `PMC_ADDR_BANK && wdata_in[`PMC_BANK_STANDBY] && quiet;
    endsequence
    a_idle_gates_cpu: assert property (s_idle_wr |-> ##2 !cpu_clk_en_out && !acq_clk_en_out
        && !disp_clk_en_out && osc_en_out) else $error("idle gating wrong");
    a_pdown_stops_osc: assert property (s_pd_wr |-> ##2 !osc_en_out)
        else $error("oscillator still on");
    a_standby_gates: assert property (s_sb_wr |-> ##2 !acq_clk_en_out && !disp_clk_en_out)
        else $error("standby gating wrong");
    a_periph_kept: assert property (osc_en_out |-> periph_clk_en_out)
        else $error("peripheral clock lost");
    a_frozen_hold: assert property (!cpu_clk_en_out |-> hold_state_out)
        else $error("state not held");
    a_aux_lost: assert property ($fell(osc_en_out) |-> ##[0:1] aux_mem_lost_out)
        else $error("aux loss not flagged");
    a_wake_resume: assert property (resume_out |=> cpu_clk_en_out && !resume_out)
        else $error("resume wrong");
    a_reset_qual: assert property (hw_reset_in && run_q == 8'h17 |-> ##[0:3] soft_reset_out)
        else $error("reset not taken");
    a_reset_early: assert property (soft_reset_out |-> run_q >= 8'h17
        || $past(run_q) >= 8'h17 || $past(run_q, 2) >= 8'h17) else $error("reset too early");
    a_reset_restore: assert property ($rose(soft_reset_out) |-> ##[0:2] cpu_clk_en_out
        && osc_en_out && acq_clk_en_out) else $error("reset left mode");
    a_read_quiet: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside slot");
endmodule // pmc_power_sva
bind pmc_power_ctrl pmc_power_sva #(.N_IRQ(N_IRQ)) u_sva (
    .clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_in,
    .ext_irq_level_n_in, .cmp_irq_in, .hw_reset_in, .cpu_clk_en_out, .acq_clk_en_out,
    .disp_clk_en_out, .periph_clk_en_out, .osc_en_out, .hold_state_out, .aux_mem_lost_out,
    .soft_reset_out, .resume_out
);

//--- tb/tb.sv
// self-checking bench for the power mode controller
`timescale 1ns/100ps
`include "pmc_regs.vh"
module tb;
    logic       clk_in = 1'b0;
    logic       nrst_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic       wr_in = 1'b0;
    logic       rd_in = 1'b0;
    logic [7:0] irq_in = 8'h00;
    logic       ext_irq_level_n_in = 1'b1;
    logic       cmp_irq_in = 1'b0;
    logic       hw_reset_in = 1'b0;
    logic       res_seen = 1'b0;
    logic       rst_seen = 1'b0;
    int         bad_count = 0;
    int         num_checks = 0;
    wire  [7:0] rdata_out;
    wire        cpu_clk_en_out, acq_clk_en_out, disp_clk_en_out, periph_clk_en_out;
    wire        sadc_clk_en_out, osc_en_out, hold_state_out, aux_mem_lost_out;
    wire        soft_reset_out, resume_out;
    wire  [9:0] mode_v = {cpu_clk_en_out, acq_clk_en_out, disp_clk_en_out, periph_clk_en_out,
                          sadc_clk_en_out, osc_en_out, hold_state_out, aux_mem_lost_out,
                          soft_reset_out, resume_out};
    pmc_power_ctrl dut (
        .clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_in,
        .ext_irq_level_n_in, .cmp_irq_in, .hw_reset_in, .cpu_clk_en_out, .acq_clk_en_out,
        .disp_clk_en_out, .periph_clk_en_out, .sadc_clk_en_out, .osc_en_out, .hold_state_out,
        .aux_mem_lost_out, .soft_reset_out, .resume_out
    );
    initial forever #2.5 clk_in = ~clk_in;
    // pulses are one cycle long, so latch them for the scenario to judge
    always @(posedge clk_in) begin
        if (resume_out === 1'b1) res_seen <= 1'b1;
        if (soft_reset_out === 1'b1) rst_seen <= 1'b1;
    end
    // ------
    // bus and helper tasks
    // ------
    task chk(input logic c, input string m);
        num_checks++;
        if (c !== 1'b1) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out === e, "read data");
    endtask
    task wake(input logic [7:0] i, input logic e, input logic c);
        res_seen = 1'b0;
        @(posedge clk_in);
        irq_in <= i;
        ext_irq_level_n_in <= e;
        cmp_irq_in <= c;
        step(6);
        @(posedge clk_in);
        irq_in <= 8'h00;
        ext_irq_level_n_in <= 1'b1;
        cmp_irq_in <= 1'b0;
        step(2);
    endtask
    task hwr(input int n);
        rst_seen = 1'b0;
        @(posedge clk_in);
        hw_reset_in <= 1'b1;
        repeat (n) @(posedge clk_in);
        hw_reset_in <= 1'b0;
        step(3);
    endtask
    // ------
    // scenarios
    // ------
    task t_regs;
        chk(mode_v === 10'h3f0, "reset levels");
        wr(`PMC_ADDR_WAKE_EN, 8'h5a);
        rd(`PMC_ADDR_WAKE_EN, 8'h5a);
        rd(`PMC_ADDR_POWER_CONTROL_REG, 8'h00);
        rd(`PMC_ADDR_BANK, 8'h00);
        rd(4'hf, 8'h00);
    endtask
    task t_idle;
        wr(`PMC_ADDR_WAKE_EN, 8'hfe);
        wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h01);
        step(2);
        chk(mode_v === 10'h058, "idle levels");
        wake(8'h01, 1'b1, 1'b0);
        chk(res_seen === 1'b0 && cpu_clk_en_out === 1'b0, "masked wake");
        wake(8'h02, 1'b1, 1'b0);
        chk(res_seen === 1'b1 && mode_v[9:2] === 8'hfc, "irq wake");
        rd(`PMC_ADDR_POWER_CONTROL_REG, 8'h00);
        wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h01);
        step(2);
        wake(8'h00, 1'b1, 1'b1);
        chk(res_seen === 1'b1 && cpu_clk_en_out === 1'b1, "compare wake");
    endtask
    task t_pdown;
        wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h02);
        step(2);
        chk(mode_v[9] === 1'b0 && mode_v[4] === 1'b0 && mode_v[2] === 1'b1, "pdown");
        wake(8'h00, 1'b0, 1'b0);
        chk(res_seen === 1'b1 && osc_en_out === 1'b1, "ext wake");
        wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h03);
        step(2);
        chk(osc_en_out === 1'b0, "both bits");
        wake(8'h00, 1'b1, 1'b1);
        chk(res_seen === 1'b1 && osc_en_out === 1'b1, "compare pdown wake");
        rd(`PMC_ADDR_STATUS, 8'h18);
        rd(`PMC_ADDR_STATUS, 8'h08);
        chk(aux_mem_lost_out === 1'b0, "aux flag cleared");
    endtask
    task t_standby;
        wr(`PMC_ADDR_BANK, 8'h80);
        step(2);
        chk(mode_v[9:3] === 7'h4e, "standby levels");
        wr(`PMC_ADDR_WAKE_EN, 8'hff);
        wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h01);
        step(2);
        wake(8'h04, 1'b1, 1'b0);
        chk(res_seen === 1'b1 && mode_v[9:7] === 3'b100, "standby kept");
    endtask
    task t_hwrst;
        wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h01);
        step(2);
        hwr(10);
        chk(rst_seen === 1'b0 && cpu_clk_en_out === 1'b0, "short reset");
        hwr(30);
        chk(rst_seen === 1'b1 && mode_v[9:4] === 6'h3f, "reset exit");
        rd(`PMC_ADDR_BANK, 8'h00);
        wr(`PMC_ADDR_POWER_CONTROL_REG, 8'h02);
        step(2);
        hwr(30);
        chk(rst_seen === 1'b1 && osc_en_out === 1'b1, "pdown reset");
    endtask
    task conclude;
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        step(1);
        t_regs;
        t_idle;
        t_pdown;
        t_standby;
        t_hwrst;
        conclude;
    end
    initial begin
        #20000;
        bad_count++;
        conclude;
    end
endmodule // tb
